// *** sff_fifo.sv ***
// Sensor FIFO frame builder, overflow handling and readout with APB registers
// Summary of operation
// - Headerless stores fixed-size regular frames only.
// - Headerless size-affecting change flushes FIFO.
// - Aux slot always eight bytes, padded.
// - Aux bytes 0-7, then XYZ low/high.
// - Frame rate follows fastest enabled sensor.
// - Unfiltered accelerometer enters at 1600 Hz.
// - Accelerometer input divided by two to k.
// - Overwrite mode drops oldest outside host reads, skip frame follows.
// - Stop mode drops newest, skip frame follows.
// - Drops during host read set error flag.
// - Control opcodes skip, time, config, drop.
// - Fill level counts config and drop, not skip or time frames.
// - Skip frame first, saturating count, unstored.
// - Time frame last when burst empties FIFO.
// - Config frame precedes first new-config frame.
// - Config payload bits 5,4,1,0 mark changes.
// - Drop payload bit2 aux, bit0 accel.
// - Drop frame only when no sensor valid.
// - No drop frames outside config transitions.
// - Partially read frame repeated whole next time.
// - Overreads return fixed invalid pattern.
// - Header: type 7:6, param 5:2, tags 1:0.
// - Param bit0 accel, bit2 aux; empty frames unstored.
// - Storage holds 1024 bytes.
`timescale 1ns/100ps
module sff_fifo import sff_pkg::*; #(
  parameter int DEPTH = FIFO_BYTES
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample sources
  input wire logic odr_tick,
  input wire logic acc_valid,
  input wire logic [15:0] acc_x,
  input wire logic [15:0] acc_y,
  input wire logic [15:0] acc_z,
  input wire logic aux_valid,
  input wire logic [63:0] aux_data,
  input wire logic [23:0] sensortime
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);

  function automatic logic [7:0] hdr_byte(input logic [1:0] t, input logic [3:0] p);
    hdr_byte = {t, p, 2'b00};
  endfunction : hdr_byte

  function automatic logic [4:0] frame_len(input logic [7:0] h, input logic hm,
                                           input logic ae, input logic xe);
    logic [4:0] n;
    n = 5'h00;
    if (!hm) begin
      n = (ae ? ACC_BYTES : 5'h00) + (xe ? AUX_SLOT : 5'h00);
    end else if (h[7:6] == TYPE_CONTROL) begin
      n = 5'h02;
    end else begin
      n = 5'h01 + (h[2+PARAM_AUX] ? AUX_SLOT : 5'h00) + (h[2+PARAM_ACC] ? ACC_BYTES : 5'h00);
    end
    frame_len = n;
  endfunction : frame_len

  logic [7:0] mem [0:DEPTH-1];
  logic [CFG_WIDTH-1:0] cfg_reg, cfg_next;
  logic [7:0] pend_reg, pend_next;
  logic err_reg, err_next;
  logic [7:0] skip_reg, skip_next;
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next, fstart_reg, fstart_next;
  logic [4:0] left_reg, left_next;
  logic burst_reg, burst_next, got_reg, got_next;
  sff_phase_type phase_reg, phase_next;
  logic [1:0] tidx_reg, tidx_next;
  logic tog_reg, tog_next;
  logic [23:0] time_reg, time_next;
  sff_wstate_type ws_reg, ws_next;
  logic [7:0] wbuf_reg [0:18];
  logic [7:0] wbuf_next [0:18];
  logic [4:0] wlen_reg, wlen_next, widx_reg, widx_next;
  logic acct_reg, acct_next, auxt_reg, auxt_next;
  logic [6:0] down_reg, down_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic mem_we;

  logic hm, sof, ten, acc_en, aux_en, unfilt;
  logic [2:0] downs;
  logic [1:0] burst_code;
  logic [AW:0] level, free;
  logic acc_cand, acc_ev, aux_ev, drop_ev, any_ev;
  logic [6:0] down_mask;

  assign hm = cfg_reg[CFG_HDR_EN];
  assign sof = cfg_reg[CFG_STOP_FULL];
  assign ten = cfg_reg[CFG_TIME_EN];
  assign acc_en = cfg_reg[CFG_ACC_EN];
  assign aux_en = cfg_reg[CFG_AUX_EN];
  assign downs = cfg_reg[CFG_DOWNS_LSB +: 3];
  assign unfilt = cfg_reg[CFG_UNFILT];
  assign burst_code = cfg_reg[CFG_BURST_LSB +: 2];
  assign level = wr_reg - rd_reg;
  assign free = DEPTH_P - level;
  // Unfiltered path is paced by the 1600 Hz base tick
  assign acc_cand = acc_en & (unfilt ? odr_tick : acc_valid);
  assign down_mask = 7'((8'h01 << downs) - 8'h01);
  assign acc_ev = acc_cand & ((down_reg & down_mask) == 7'h00);
  assign aux_ev = aux_en & aux_valid;
  assign drop_ev = hm & odr_tick & ((acc_en & acct_reg) | (aux_en & auxt_reg))
                   & ~acc_ev & ~aux_ev;
  assign any_ev = acc_ev | aux_ev | drop_ev;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  always_comb begin
    logic [4:0] n;
    logic [4:0] burst_bytes;
    logic [7:0] b;
    logic [4:0] fl;
    logic rd_take, other_take, wr_do, is_data, mapped, flush, inc_acc, inc_aux, drop_now;
    logic [47:0] accw;
    logic [CFG_WIDTH-1:0] wcfg;
    sff_phase_type eph;
    n = 5'h00;
    burst_bytes = 5'h00;
    b = 8'h00;
    fl = 5'h00;
    wcfg = pwdata[CFG_WIDTH-1:0];
    cfg_next = cfg_reg;
    pend_next = pend_reg;
    err_next = err_reg;
    skip_next = skip_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    fstart_next = fstart_reg;
    left_next = left_reg;
    burst_next = burst_reg;
    got_next = got_reg;
    phase_next = phase_reg;
    tidx_next = tidx_reg;
    tog_next = tog_reg;
    time_next = time_reg;
    ws_next = ws_reg;
    wbuf_next = wbuf_reg;
    wlen_next = wlen_reg;
    widx_next = widx_reg;
    acct_next = acct_reg;
    auxt_next = auxt_reg;
    down_next = acc_cand ? down_reg + 7'h01 : down_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    mem_we = 1'b0;
    flush = 1'b0;
    drop_now = 1'b0;
    inc_acc = 1'b0;
    inc_aux = 1'b0;
    accw = {acc_z, acc_y, acc_x};
    case (burst_code)
      2'h0: burst_bytes = 5'h01;
      2'h1: burst_bytes = 5'h02;
      2'h2: burst_bytes = 5'h06;
      default: burst_bytes = 5'h08;
    endcase

    // APB: reads commit when data is latched, writes at the completing edge
    is_data = (paddr == ADDR_DATA) & ~pwrite;
    mapped = (paddr == ADDR_CONFIG) | (paddr == ADDR_CHANGE) | (paddr == ADDR_DATA)
             | (paddr == ADDR_LEVEL) | (paddr == ADDR_STATUS);
    rd_take = psel & ~pready_reg & is_data & (ws_reg != WS_TRIM);
    other_take = psel & ~pready_reg & ~is_data;
    pready_next = psel & ~pready_reg & ~(is_data & (ws_reg == WS_TRIM));
    wr_do = psel & penable & pready_reg & pwrite;
    if (pready_next) begin
      pslverr_next = ~mapped;
      prdata_next = 32'h0000_0000;
      case (paddr)
        ADDR_CONFIG: prdata_next = 32'(cfg_reg);
        ADDR_CHANGE: prdata_next = 32'(pend_reg);
        // A cut frame is rewound at this edge, so count it as unread
        ADDR_LEVEL: prdata_next = 32'((burst_reg && left_reg != 5'h00) ? wr_reg - fstart_reg : level);
        ADDR_STATUS: prdata_next = 32'(err_reg);
        default: prdata_next = 32'h0000_0000;
      endcase
    end

    // Readout
    eph = burst_reg ? phase_reg : ((hm && skip_reg != 8'h00) ? PH_SKIP_HDR : PH_DATA);
    if (rd_take) begin
      burst_next = 1'b1;
      phase_next = eph;
      case (eph)
        PH_SKIP_HDR: begin
          b = hdr_byte(TYPE_CONTROL, OP_SKIP);
          phase_next = PH_SKIP_CNT;
        end
        PH_SKIP_CNT: begin
          b = skip_reg;
          skip_next = 8'h00;
          phase_next = PH_DATA;
        end
        PH_DATA: begin
          if (level != {(AW+1){1'b0}}) begin
            b = mem[rd_reg[AW-1:0]];
            if (left_reg == 5'h00) begin
              fl = frame_len(b, hm, acc_en, aux_en);
              fstart_next = rd_reg;
              left_next = fl - 5'h01;
            end else begin
              left_next = left_reg - 5'h01;
            end
            if (left_next == 5'h00) begin
              time_next = sensortime;
              got_next = 1'b1;
            end
            rd_next = rd_reg + (AW+1)'(1);
          end else if (hm && ten && got_reg) begin
            b = hdr_byte(TYPE_CONTROL, OP_TIME);
            phase_next = PH_TIME;
            tidx_next = 2'h0;
          end else begin
            b = hm ? OVER_HDR_WORD_LO : OVER_RAW_WORD_LO;
            tog_next = 1'b1;
            phase_next = PH_OVER;
          end
        end
        PH_TIME: begin
          b = time_reg[8*tidx_reg +: 8];
          tidx_next = tidx_reg + 2'h1;
          if (tidx_reg == 2'h2) begin
            phase_next = PH_OVER;
            tog_next = 1'b0;
          end
        end
        default: begin
          if (hm) begin
            b = tog_reg ? OVER_HDR_WORD_HI : OVER_HDR_WORD_LO;
          end else begin
            b = tog_reg ? OVER_RAW_WORD_HI : OVER_RAW_WORD_LO;
          end
          tog_next = ~tog_reg;
        end
      endcase
      prdata_next = {24'h000000, b};
    end else if (other_take && burst_reg) begin
      burst_next = 1'b0;
      got_next = 1'b0;
      tog_next = 1'b0;
      phase_next = PH_DATA;
      if (left_reg != 5'h00) begin
        rd_next = fstart_reg;
        left_next = 5'h00;
      end
    end

    // Writer
    case (ws_reg)
      WS_IDLE: begin
        if (any_ev) begin
          n = 5'h00;
          if (pend_reg != 8'h00 && hm) begin
            wbuf_next[n] = hdr_byte(TYPE_CONTROL, OP_INCFG);
            wbuf_next[n+5'h01] = pend_reg;
            n = n + 5'h02;
            acct_next = acc_en & (pend_reg[CHG_ACC_SETUP] | pend_reg[CHG_ACC_SCALE]);
            auxt_next = aux_en & (pend_reg[CHG_AUX_SETUP] | pend_reg[CHG_AUX_LINK]);
          end
          pend_next = 8'h00;
          if (drop_ev) begin
            wbuf_next[n] = hdr_byte(TYPE_CONTROL, OP_DROP);
            wbuf_next[n+5'h01] = {5'h00, aux_en & auxt_reg, 1'b0, acc_en & acct_reg};
            n = n + 5'h02;
          end
          // Headerless keeps every enabled slot so frames stay equal in size
          inc_acc = hm ? acc_ev : acc_en & (acc_ev | aux_ev);
          inc_aux = hm ? aux_ev : aux_en & (acc_ev | aux_ev);
          if (inc_acc || inc_aux) begin
            if (hm) begin
              wbuf_next[n] = {TYPE_REGULAR, 1'b0, inc_aux, 1'b0, inc_acc, 2'b00};
              n = n + 5'h01;
            end
            if (inc_aux) begin
              for (int i = 0; i < 8; i++) begin
                wbuf_next[n] = (5'(i) < burst_bytes && aux_ev) ? aux_data[8*i +: 8]
                               : PAD_BYTE;
                n = n + 5'h01;
              end
            end
            if (inc_acc) begin
              for (int i = 0; i < 6; i++) begin
                wbuf_next[n] = acc_ev ? accw[8*i +: 8] : PAD_BYTE;
                n = n + 5'h01;
              end
            end
          end
          if (acc_ev) begin
            acct_next = 1'b0;
          end
          if (aux_ev) begin
            auxt_next = 1'b0;
          end
          wlen_next = n;
          widx_next = 5'h00;
          if (n != 5'h00) begin
            if (free < (AW+1)'(FRAME_MAX) || free < (AW+1)'(n)) begin
              if (sof || burst_reg || rd_take) begin
                ws_next = WS_IDLE;
                if (hm && skip_reg != SKIP_MAX) begin
                  skip_next = skip_reg + 8'h01;
                end
                err_next = 1'b1;
                drop_now = 1'b1;
              end else begin
                ws_next = WS_TRIM;
              end
            end else begin
              ws_next = WS_WRITE;
            end
          end
        end
      end
      WS_TRIM: begin
        // Drop whole oldest frames until FRAME_MAX bytes and the new data both fit
        if (free < (AW+1)'(FRAME_MAX) || free < (AW+1)'(wlen_reg)) begin
          rd_next = rd_reg + (AW+1)'(frame_len(mem[rd_reg[AW-1:0]], hm, acc_en, aux_en));
          if (hm && skip_reg != SKIP_MAX) begin
            skip_next = skip_reg + 8'h01;
          end
        end else begin
          ws_next = WS_WRITE;
        end
      end
      WS_WRITE: begin
        mem_we = 1'b1;
        wr_next = wr_reg + (AW+1)'(1);
        widx_next = widx_reg + 5'h01;
        if (widx_reg == wlen_reg - 5'h01) begin
          ws_next = WS_IDLE;
        end
      end
      default: ws_next = WS_IDLE;
    endcase

    // Register writes; hardware sets win over software clears
    if (wr_do) begin
      case (paddr)
        ADDR_CONFIG: begin
          cfg_next = wcfg;
          if (wcfg[CFG_HDR_EN] != hm) begin
            flush = 1'b1;
          end
          if (!wcfg[CFG_HDR_EN] && (wcfg[CFG_ACC_EN] != acc_en || wcfg[CFG_AUX_EN] != aux_en
              || wcfg[CFG_BURST_LSB +: 2] != burst_code)) begin
            flush = 1'b1;
          end
          if (acc_en && wcfg[CFG_DOWNS_LSB +: 4] != cfg_reg[CFG_DOWNS_LSB +: 4]) begin
            pend_next[CHG_ACC_SETUP] = 1'b1;
          end
          if (aux_en && wcfg[CFG_BURST_LSB +: 2] != burst_code) begin
            pend_next[CHG_AUX_LINK] = 1'b1;
          end
        end
        ADDR_CHANGE: pend_next = pend_next | (pwdata[7:0] & CHG_MASK);
        ADDR_STATUS: begin
          if (pwdata[0] && !drop_now) begin
            err_next = 1'b0;
          end
        end
        default: pend_next = pend_next;
      endcase
    end
    if (flush) begin
      wr_next = {(AW+1){1'b0}};
      rd_next = {(AW+1){1'b0}};
      fstart_next = {(AW+1){1'b0}};
      left_next = 5'h00;
      skip_next = 8'h00;
      ws_next = WS_IDLE;
      mem_we = 1'b0;
      pend_next = 8'h00;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[wr_reg[AW-1:0]] <= wbuf_reg[widx_reg];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
      pend_reg <= 8'h00;
      err_reg <= 1'b0;
      skip_reg <= 8'h00;
      wr_reg <= '0;
      rd_reg <= '0;
      fstart_reg <= '0;
      left_reg <= 5'h00;
      burst_reg <= 1'b0;
      got_reg <= 1'b0;
      phase_reg <= PH_DATA;
      tidx_reg <= 2'h0;
      tog_reg <= 1'b0;
      time_reg <= 24'h000000;
      ws_reg <= WS_IDLE;
      for (int i = 0; i < 19; i++) begin
        wbuf_reg[i] <= 8'h00;
      end
      wlen_reg <= 5'h00;
      widx_reg <= 5'h00;
      acct_reg <= 1'b0;
      auxt_reg <= 1'b0;
      down_reg <= 7'h00;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      pend_reg <= pend_next;
      err_reg <= err_next;
      skip_reg <= skip_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      fstart_reg <= fstart_next;
      left_reg <= left_next;
      burst_reg <= burst_next;
      got_reg <= got_next;
      phase_reg <= phase_next;
      tidx_reg <= tidx_next;
      tog_reg <= tog_next;
      time_reg <= time_next;
      ws_reg <= ws_next;
      wbuf_reg <= wbuf_next;
      wlen_reg <= wlen_next;
      widx_reg <= widx_next;
      acct_reg <= acct_next;
      auxt_reg <= auxt_next;
      down_reg <= down_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end
endmodule : sff_fifo

// *** sff_pkg.sv ***
// Constants and types for the sensor FIFO framing block
package sff_pkg;
  localparam int FIFO_BYTES = 1024;
  localparam int BASE_RATE_HZ = 1600;
  localparam int CLK_HZ = 40000000;
  localparam logic [4:0] FRAME_MAX = 5'h0F;
  localparam logic [4:0] WBUF_LEN = 5'h13;
  localparam logic [4:0] AUX_SLOT = 5'h08;
  localparam logic [4:0] ACC_BYTES = 5'h06;
  // Register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CHANGE = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Config register fields
  localparam int CFG_HDR_EN = 0;
  localparam int CFG_STOP_FULL = 1;
  localparam int CFG_TIME_EN = 2;
  localparam int CFG_ACC_EN = 3;
  localparam int CFG_AUX_EN = 4;
  localparam int CFG_DOWNS_LSB = 5;
  localparam int CFG_UNFILT = 8;
  localparam int CFG_BURST_LSB = 9;
  localparam int CFG_WIDTH = 11;
  localparam logic [10:0] CFG_RESET = 11'h001;
  // Input-config payload bits
  localparam int CHG_ACC_SETUP = 0;
  localparam int CHG_ACC_SCALE = 1;
  localparam int CHG_AUX_SETUP = 4;
  localparam int CHG_AUX_LINK = 5;
  localparam logic [7:0] CHG_MASK = 8'h33;
  // Sample drop payload bits
  localparam int DROP_ACC = 0;
  localparam int DROP_AUX = 2;
  // Header layout and codes
  localparam logic [1:0] TYPE_REGULAR = 2'h2;
  localparam logic [1:0] TYPE_CONTROL = 2'h1;
  localparam logic [3:0] OP_SKIP = 4'h0;
  localparam logic [3:0] OP_TIME = 4'h1;
  localparam logic [3:0] OP_INCFG = 4'h2;
  localparam logic [3:0] OP_DROP = 4'h4;
  localparam int PARAM_ACC = 0;
  localparam int PARAM_AUX = 2;
  localparam logic [7:0] OVER_HDR_WORD_LO = 8'h80;
  localparam logic [7:0] OVER_HDR_WORD_HI = 8'h00;
  localparam logic [7:0] OVER_RAW_WORD_LO = 8'h00;
  localparam logic [7:0] OVER_RAW_WORD_HI = 8'h80;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [7:0] SKIP_MAX = 8'hFF;

  typedef enum logic [2:0] {PH_SKIP_HDR, PH_SKIP_CNT, PH_DATA, PH_TIME, PH_OVER} sff_phase_type;
  typedef enum logic [1:0] {WS_IDLE, WS_TRIM, WS_WRITE} sff_wstate_type;
endpackage : sff_pkg

// *** sff_src_model.sv ***
// Sample source model: grid ticks, sample strobes and sensortime
`timescale 1ns/100ps
module sff_src_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic fire,
  input wire logic aux_on,
  // Sample strobes and time
  output logic odr_tick,
  output logic acc_valid,
  output logic aux_valid,
  output logic [23:0] sensortime
);
  // Time moves only on grid ticks, so reads see a stable value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odr_tick <= 1'b0;
      acc_valid <= 1'b0;
      aux_valid <= 1'b0;
      sensortime <= 24'h000000;
    end else begin
      odr_tick <= fire;
      acc_valid <= fire;
      aux_valid <= fire & aux_on;
      if (fire) begin
        sensortime <= sensortime + 24'h000001;
      end
    end
  end
endmodule : sff_src_model

// *** sff_fifo_assertions.sv ***
// Checker of the bus-side behaviour of the FIFO block
`timescale 1ns/100ps
module sff_fifo_assertions import sff_pkg::*; #(
  parameter int DEPTH = FIFO_BYTES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic mapped;
  logic rd_ok;
  assign mapped = paddr inside {ADDR_CONFIG, ADDR_CHANGE, ADDR_DATA, ADDR_LEVEL, ADDR_STATUS};
  assign rd_ok = pready && !pwrite && !pslverr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // Trimming may stall a data read for a few cycles
  AST_ANSWER_BOUND: assert property ((psel && !penable) |-> ##[1:40] pready)
    else $error("no answer to access");
  AST_UNMAPPED_ERR: assert property (pready |-> (pslverr == !mapped))
    else $error("error flag wrong for address");
  AST_UNMAPPED_ZERO: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_DATA_BYTE: assert property ((rd_ok && paddr == ADDR_DATA) |-> prdata[31:8] == 24'h0)
    else $error("data port wider than a byte");
  AST_LEVEL_BOUND: assert property ((rd_ok && paddr == ADDR_LEVEL) |-> prdata <= DEPTH)
    else $error("level beyond storage");
  AST_CHANGE_BITS: assert property ((rd_ok && paddr == ADDR_CHANGE) |-> (prdata & ~32'h33) == 0)
    else $error("reserved change bits set");
  AST_STATUS_BITS: assert property ((rd_ok && paddr == ADDR_STATUS) |-> prdata[31:1] == 0)
    else $error("reserved status bits set");
  C_DATA: cover property (rd_ok && paddr == ADDR_DATA);
  C_ERR: cover property (pready && pslverr);
  C_FLAG: cover property (rd_ok && paddr == ADDR_STATUS && prdata[0]);
endmodule : sff_fifo_assertions

bind sff_fifo sff_fifo_assertions #(.DEPTH(DEPTH)) chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** sff_fifo_tb.sv ***
// Self-checking bench for the sensor FIFO framing block
`timescale 1ns/100ps
module sff_fifo_tb import sff_pkg::*; ();
  localparam int DEP = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, aux_on;
  logic odr_tick, acc_valid, aux_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, e, m;
  logic [15:0] ax, ay, az;
  logic [63:0] aux_data;
  logic [23:0] stime;
  logic [7:0] mq[$];
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int seed = 85;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int ticks = 0;

  always #12.5 pclk = ~pclk;

  sff_fifo #(.DEPTH(DEP)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .odr_tick(odr_tick), .acc_valid(acc_valid), .acc_x(ax), .acc_y(ay),
    .acc_z(az), .aux_valid(aux_valid), .aux_data(aux_data), .sensortime(stime));

  sff_src_model src_u (.pclk(pclk), .presetn(presetn), .fire(fire), .aux_on(aux_on),
    .odr_tick(odr_tick), .acc_valid(acc_valid), .aux_valid(aux_valid), .sensortime(stime));

  task check(string name, logic [31:0] seen, logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task give_verdict();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Watcher takes the oldest note whenever a read completes
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      give_verdict();
    end
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check("read data", prdata & m, e);
    end
  end

  task apb(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(logic [7:0] a, logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rd(logic [7:0] a, logic [31:0] x, logic [31:0] k = 32'hFFFFFFFF);
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task rdq(int n);
    repeat (n) rd(ADDR_DATA, {24'h0, mq.pop_front()});
  endtask : rdq

  task tick(logic aux);
    @(posedge pclk);
    fire <= 1'b1;
    aux_on <= aux;
    @(posedge pclk);
    fire <= 1'b0;
    ticks++;
    repeat (25) @(posedge pclk);
  endtask : tick

  task newsamp();
    @(posedge pclk);
    ax <= $random(seed);
    ay <= $random(seed);
    az <= $random(seed);
    aux_data <= {$random(seed), $random(seed)};
    @(posedge pclk);
  endtask : newsamp

  task pacc();
    mq.push_back(ax[7:0]);
    mq.push_back(ax[15:8]);
    mq.push_back(ay[7:0]);
    mq.push_back(ay[15:8]);
    mq.push_back(az[7:0]);
    mq.push_back(az[15:8]);
  endtask : pacc

  task pair(logic [7:0] lo, logic [7:0] hi);
    mq.push_back(lo);
    mq.push_back(hi);
  endtask : pair

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, fire, aux_on} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {ax, ay, az} = 48'h0;
    aux_data = 64'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONFIG, 32'h001);
    rd(ADDR_LEVEL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h14, 32'h0);
    pair(8'h80, 8'h00);
    rdq(2);
    // Config frame with every change bit
    newsamp();
    wr(ADDR_CONFIG, 32'h009);
    wr(ADDR_CONFIG, 32'h109);
    wr(ADDR_CHANGE, 32'hFF);
    rd(ADDR_CHANGE, 32'h33);
    tick(1'b0);
    pair(8'h48, 8'h33);
    mq.push_back(8'h84);
    pacc();
    rd(ADDR_LEVEL, 32'h09);
    rdq(9);
    // Partial read, rewind, then time frame
    wr(ADDR_CONFIG, 32'h10D);
    newsamp();
    tick(1'b0);
    mq.push_back(8'h84);
    pacc();
    for (int i = 0; i < 3; i++) rd(ADDR_DATA, {24'h0, mq[i]});
    rd(ADDR_LEVEL, 32'h07);
    rdq(7);
    pair(8'h44, ticks[7:0]);
    pair(ticks[15:8], ticks[23:16]);
    pair(8'h80, 8'h00);
    rdq(6);
    // Stop on full: newest dropped, skip counted
    wr(ADDR_CONFIG, 32'h10B);
    newsamp();
    repeat (11) tick(1'b0);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_LEVEL, 32'h38);
    pair(8'h40, 8'h03);
    repeat (8) begin
      mq.push_back(8'h84);
      pacc();
    end
    pair(8'h80, 8'h00);
    rdq(60);
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    // Down-sampling by four
    wr(ADDR_CONFIG, 32'h14B);
    repeat (8) tick(1'b0);
    rd(ADDR_LEVEL, 32'h10);
    pair(8'h48, 8'h01);
    repeat (2) begin
      mq.push_back(8'h84);
      pacc();
    end
    rdq(16);
    // Headerless with a two-byte aux burst
    wr(ADDR_CONFIG, 32'h318);
    newsamp();
    tick(1'b1);
    pair(aux_data[7:0], aux_data[15:8]);
    repeat (6) mq.push_back(PAD_BYTE);
    pacc();
    rd(ADDR_LEVEL, 32'h0E);
    rdq(14);
    pair(8'h00, 8'h80);
    rdq(2);
    tick(1'b1);
    wr(ADDR_CONFIG, 32'h718);
    rd(ADDR_LEVEL, 32'h0);
    tick(1'b1);
    for (int i = 0; i < 8; i++) mq.push_back(aux_data[8*i +: 8]);
    pacc();
    rdq(14);
    give_verdict();
  end
endmodule : sff_fifo_tb
